// ==== emnv_map.svh ====
// Constants of the emulated nonvolatile store record manager
`ifndef EMNV_MAP_SVH
`define EMNV_MAP_SVH
`define EMNV_SECT_BYTES 256
`define EMNV_NUM_SECT 4
`define EMNV_ADDR_W 10
`define EMNV_CNT_W 11
`define EMNV_SECT_W 3
`define EMNV_ERASED 8'hff
`define EMNV_CLK_NS 10
`define EMNV_PROG_NS 100
`define EMNV_PROG_CYC ((`EMNV_PROG_NS + `EMNV_CLK_NS - 1) / `EMNV_CLK_NS)
`define EMNV_TMR_W 8
`endif

// ==== emnv_pkg.sv ====
// Types of the emulated nonvolatile store record manager
`include "emnv_map.svh"
package emnv_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RESTORE = 5'h02,
        ST_ERASE = 5'h04,
        ST_ENWALK = 5'h08,
        ST_PROG = 5'h10
    } emnv_state_t;

    typedef struct packed {
        emnv_state_t st;
        logic [`EMNV_ADDR_W-1:0] ptr;
        logic [`EMNV_CNT_W-1:0] limit;
        logic [`EMNV_TMR_W-1:0] tmr;
        logic [`EMNV_CNT_W-1:0] pend;
        logic [7:0] pdata;
        logic emu_on;
        logic busy;
        logic acc_err;
        logic ack;
        logic [7:0] rdata;
    } emnv_regs_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } emnv_rec_t;
endpackage : emnv_pkg

// ==== emnv_record_store.sv ====
// Nonvolatile record array and partition word of the emulated store
`timescale 1ns/1ps
`include "emnv_map.svh"
module emnv_record_store
    import emnv_pkg::*;
#(
    parameter int NUM_BYTES = `EMNV_SECT_BYTES * `EMNV_NUM_SECT
)
(
    // Clocking
    input wire logic clk,
    input wire logic ce,
    // Factory blank
    input wire logic blank,
    // Partition
    input wire logic erase,
    input wire logic [`EMNV_SECT_W-1:0] cfg_sects,
    output logic [`EMNV_SECT_W-1:0] sects,
    // Programming
    input wire logic prog_en,
    input wire logic [`EMNV_ADDR_W-1:0] prog_idx,
    input wire logic [7:0] prog_data,
    // Lookup
    input wire logic [`EMNV_ADDR_W-1:0] rd_idx,
    output emnv_rec_t rd_rec
);
    // Not cleared by system reset: this is the flash that outlives it
    logic [7:0] rec_data [NUM_BYTES];
    logic [NUM_BYTES-1:0] rec_valid;
    logic [`EMNV_SECT_W-1:0] sects_r;

    always_ff @(posedge clk)
    begin
        if (ce && prog_en)
        begin
            rec_data[prog_idx] <= prog_data;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_BYTES; g++)
        begin : g_valid
            always_ff @(posedge clk)
            begin
                if (ce)
                begin
                    if (blank || erase)
                        rec_valid[g] <= 1'b0;
                    else if (prog_en && prog_idx == `EMNV_ADDR_W'(g))
                        rec_valid[g] <= 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (blank)
                sects_r <= '0;
            else if (erase)
                sects_r <= cfg_sects;
        end
    end

    assign sects = sects_r;
    assign rd_rec.valid = rec_valid[rd_idx];
    assign rd_rec.data = rec_data[rd_idx];
endmodule : emnv_record_store

// ==== emnv_manager.sv ====
// Record manager: buffer RAM, partition, restore and record copying
//Contract
//- Host accesses RAM while idle or programming; records copied alongside
//- Pending counter counts unstored records, zero when done
//- After reset restore partition bytes from records
//- Host accesses stall until restore completes
//- Bytes without record restore as erased
//- Writes while management off create no record
//- Buffer RAM beyond partition untouched, not managed
//- Partition allocated in 256-byte sections from first
//- Full partition erases RAM, initialises records
//- Enable creates records for earlier written data
`timescale 1ns/1ps
`include "emnv_map.svh"
module emnv_manager
    import emnv_pkg::*;
#(
    parameter int NUM_SECT = `EMNV_NUM_SECT,
    parameter int PROG_CYC = `EMNV_PROG_CYC
)
(
    // Clock, enable, reset
    input wire logic CLOCK,
    input wire logic CE,
    input wire logic SRST,
    input wire logic BLANK_FLASH,
    // Host memory port
    input wire logic HOST_REQ,
    input wire logic HOST_WE,
    input wire logic [`EMNV_ADDR_W-1:0] HOST_ADDR,
    input wire logic [7:0] HOST_WDATA,
    output logic [7:0] HOST_RDATA,
    output logic HOST_ACK,
    // Commands
    input wire logic CMD_PARTITION,
    input wire logic [`EMNV_SECT_W-1:0] CMD_SECTIONS,
    input wire logic CMD_ENABLE,
    input wire logic CMD_DISABLE,
    // Status
    output logic MEMORY_CONTROLLER_BUSY,
    output logic [`EMNV_CNT_W-1:0] PENDING_RECORD_COUNT,
    output logic EMULATION_ON,
    output logic ACCESS_ERROR
);
    localparam int NUM_BYTES = NUM_SECT * `EMNV_SECT_BYTES;
    localparam logic [`EMNV_TMR_W-1:0] PROG_T = PROG_CYC[`EMNV_TMR_W-1:0];

    emnv_regs_t r_r;
    emnv_regs_t r_nxt;
    logic [7:0] ram [NUM_BYTES];
    logic [NUM_BYTES-1:0] dirty_r;
    logic [`EMNV_SECT_W-1:0] sects;
    emnv_rec_t rec;
    logic host_take;
    logic host_wr;
    logic host_in_part;
    logic set_host;
    logic set_walk;
    logic clr_dirty;
    logic ram_we;
    logic [`EMNV_ADDR_W-1:0] ram_waddr;
    logic [7:0] ram_wdata;
    logic store_erase;
    logic prog_en;
    logic [7:0] expect_byte;
    logic last;
    logic cmd_any;

    emnv_record_store #(.NUM_BYTES(NUM_BYTES)) u_store (
        .clk(CLOCK),
        .ce(CE),
        .blank(BLANK_FLASH),
        .erase(store_erase),
        .cfg_sects(CMD_SECTIONS),
        .sects(sects),
        .prog_en(prog_en),
        .prog_idx(r_r.ptr),
        .prog_data(r_r.pdata),
        .rd_idx(r_r.ptr),
        .rd_rec(rec)
    );

    // ------------------------------------------------------------
    // Control
    // ------------------------------------------------------------
    always_comb
    begin
        r_nxt = r_r;
        r_nxt.ack = 1'b0;
        cmd_any = CMD_PARTITION | CMD_ENABLE | CMD_DISABLE;
        host_take = HOST_REQ && !r_r.ack && (r_r.st == ST_IDLE || r_r.st == ST_PROG);
        host_wr = host_take && HOST_WE;
        host_in_part = {1'b0, HOST_ADDR} < r_r.limit;
        // only managed writes mark a record due
        set_host = host_wr && r_r.emu_on && host_in_part && !dirty_r[HOST_ADDR];
        expect_byte = rec.valid ? rec.data : `EMNV_ERASED;
        last = ({1'b0, r_r.ptr} + 1'b1) >= r_r.limit;
        set_walk = 1'b0;
        clr_dirty = 1'b0;
        ram_we = 1'b0;
        ram_waddr = HOST_ADDR;
        ram_wdata = HOST_WDATA;
        store_erase = 1'b0;
        prog_en = 1'b0;
        // host reads and writes whenever not stalled
        if (host_take)
        begin
            r_nxt.ack = 1'b1;
            r_nxt.rdata = ram[HOST_ADDR];
            ram_we = HOST_WE;
        end
        if (cmd_any)
            r_nxt.acc_err = 1'b0;
        case (r_r.st)
            ST_IDLE:
            begin
                if (cmd_any)
                begin
                    if (CMD_PARTITION)
                    begin
                        if (CMD_SECTIONS > NUM_SECT[`EMNV_SECT_W-1:0])
                            r_nxt.acc_err = 1'b1;
                        else
                        begin
                            store_erase = 1'b1;
                            // The erase walk wipes the marks of the new partition bytes, so a write now must not count
                            set_host = 1'b0;
                            r_nxt.emu_on = 1'b0;
                            r_nxt.pend = '0;
                            r_nxt.ptr = '0;
                            r_nxt.limit = `EMNV_CNT_W'(CMD_SECTIONS * `EMNV_SECT_BYTES);
                            r_nxt.st = CMD_SECTIONS == '0 ? ST_IDLE : ST_ERASE;
                        end
                    end
                    else if (CMD_ENABLE)
                    begin
                        r_nxt.emu_on = 1'b1;
                        r_nxt.ptr = '0;
                        if (r_r.limit != '0)
                            r_nxt.st = ST_ENWALK;
                    end
                    else
                        r_nxt.emu_on = 1'b0;
                end
                else if (r_r.emu_on && r_r.limit != '0)
                begin
                    if (dirty_r[r_r.ptr])
                    begin
                        r_nxt.pdata = ram[r_r.ptr];
                        r_nxt.tmr = PROG_T;
                        r_nxt.st = ST_PROG;
                    end
                    else
                        r_nxt.ptr = last ? '0 : r_r.ptr + 1'b1;
                end
            end
            ST_PROG:
            begin
                if (cmd_any)
                    r_nxt.acc_err = 1'b1;
                // a rewrite during the pulse is what gets stored
                if (host_wr && HOST_ADDR == r_r.ptr)
                    r_nxt.pdata = HOST_WDATA;
                if (r_r.tmr <= `EMNV_TMR_W'(1))
                begin
                    prog_en = 1'b1;
                    // a rewrite of this byte keeps it due
                    if (!(host_wr && HOST_ADDR == r_r.ptr))
                    begin
                        clr_dirty = 1'b1;
                        r_nxt.pend = r_r.pend - 1'b1;
                    end
                    r_nxt.ptr = last ? '0 : r_r.ptr + 1'b1;
                    r_nxt.st = ST_IDLE;
                end
                else
                    r_nxt.tmr = r_r.tmr - 1'b1;
            end
            ST_ENWALK:
            begin
                if (cmd_any)
                    r_nxt.acc_err = 1'b1;
                // earlier writes that differ from the record become due
                if (ram[r_r.ptr] != expect_byte && !dirty_r[r_r.ptr])
                    set_walk = 1'b1;
                r_nxt.ptr = last ? '0 : r_r.ptr + 1'b1;
                if (last)
                    r_nxt.st = ST_IDLE;
            end
            ST_ERASE, ST_RESTORE:
            begin
                if (cmd_any)
                    r_nxt.acc_err = 1'b1;
                ram_we = 1'b1;
                ram_waddr = r_r.ptr;
                ram_wdata = r_r.st == ST_RESTORE ? expect_byte : `EMNV_ERASED;
                clr_dirty = 1'b1;
                r_nxt.ptr = last ? '0 : r_r.ptr + 1'b1;
                if (last)
                    r_nxt.st = ST_IDLE;
            end
            default:
                r_nxt.st = ST_IDLE;
        endcase
        if (set_host || set_walk)
            r_nxt.pend = r_nxt.pend + 1'b1;
        r_nxt.busy = r_nxt.st != ST_IDLE;
        if (SRST)
        begin
            r_nxt = '0;
            r_nxt.limit = `EMNV_CNT_W'(sects * `EMNV_SECT_BYTES);
            // restore only when a partition exists
            r_nxt.st = sects != '0 ? ST_RESTORE : ST_IDLE;
            r_nxt.busy = sects != '0;
            set_host = 1'b0;
            set_walk = 1'b0;
            clr_dirty = 1'b0;
            ram_we = 1'b0;
            store_erase = 1'b0;
            prog_en = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK)
    begin
        if (CE)
            r_r <= r_nxt;
    end

    // RAM has no reset, so buffer bytes survive a system reset
    always_ff @(posedge CLOCK)
    begin
        if (CE && ram_we)
            ram[ram_waddr] <= ram_wdata;
    end

    // Set wins: a host write beats the clear of the byte just stored
    genvar g;
    generate
        for (g = 0; g < NUM_BYTES; g++)
        begin : g_dirty
            always_ff @(posedge CLOCK)
            begin
                if (CE)
                begin
                    if (SRST)
                        dirty_r[g] <= 1'b0;
                    else if ((set_host && HOST_ADDR == `EMNV_ADDR_W'(g)) ||
                             (set_walk && r_r.ptr == `EMNV_ADDR_W'(g)))
                        dirty_r[g] <= 1'b1;
                    else if (clr_dirty && r_r.ptr == `EMNV_ADDR_W'(g))
                        dirty_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign HOST_RDATA = r_r.rdata;
    assign HOST_ACK = r_r.ack;
    assign MEMORY_CONTROLLER_BUSY = r_r.busy;
    assign PENDING_RECORD_COUNT = r_r.pend;
    assign EMULATION_ON = r_r.emu_on;
    assign ACCESS_ERROR = r_r.acc_err;
endmodule : emnv_manager

// ==== emnv_manager_sva.sv ====
// Port checker of the emulated store record manager
`timescale 1ns/1ps
`include "emnv_map.svh"
module emnv_manager_sva
#(
    parameter int NUM_SECT = 4,
    parameter int PROG_CYC = 10
)
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // Host port
    input wire logic HOST_REQ,
    input wire logic HOST_ACK,
    // Commands
    input wire logic CMD_PARTITION,
    input wire logic [`EMNV_SECT_W-1:0] CMD_SECTIONS,
    input wire logic CMD_ENABLE,
    input wire logic CMD_DISABLE,
    // Status
    input wire logic MEMORY_CONTROLLER_BUSY,
    input wire logic [`EMNV_CNT_W-1:0] PENDING_RECORD_COUNT,
    input wire logic EMULATION_ON,
    input wire logic ACCESS_ERROR
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);

    // Busy stretch that began with a reset; only the restore can hold it
    logic rest_r;
    always_ff @(posedge CLOCK)
        rest_r <= SRST | (rest_r & MEMORY_CONTROLLER_BUSY);

    // Cycles since the pending count last fell while work is outstanding.
    // Bound: enable walk, two full scans and two programming pulses.
    localparam logic [15:0] DRAIN_MAX = 16'(3 * NUM_SECT * `EMNV_SECT_BYTES + 2 * PROG_CYC + 8);
    logic [`EMNV_CNT_W-1:0] pend_q;
    logic [15:0] stall_cnt;
    always_ff @(posedge CLOCK)
    begin
        pend_q <= PENDING_RECORD_COUNT;
        if (SRST || !EMULATION_ON || PENDING_RECORD_COUNT == '0 || PENDING_RECORD_COUNT < pend_q)
            stall_cnt <= 16'h0000;
        else if (stall_cnt != 16'hffff)
            stall_cnt <= stall_cnt + 16'h0001;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_taken;
        HOST_REQ && !HOST_ACK && !MEMORY_CONTROLLER_BUSY;
    endsequence
    sequence s_idle(c);
        c && !MEMORY_CONTROLLER_BUSY;
    endsequence

    property p_ack_pulse;
        HOST_ACK |=> !HOST_ACK;
    endproperty
    property p_ack_idle;
        s_taken |=> HOST_ACK;
    endproperty
    property p_restore_stall;
        rest_r |-> !HOST_ACK;
    endproperty
    property p_off_nopend;
        !EMULATION_ON && $past(!EMULATION_ON) |-> PENDING_RECORD_COUNT <= $past(PENDING_RECORD_COUNT);
    endproperty
    property p_pend_drain;
        stall_cnt <= DRAIN_MAX;
    endproperty
    property p_part;
        s_idle(CMD_PARTITION) ##0 (CMD_SECTIONS != 0 && CMD_SECTIONS <= NUM_SECT)
            |=> MEMORY_CONTROLLER_BUSY && !EMULATION_ON && PENDING_RECORD_COUNT == 0;
    endproperty
    property p_enable;
        s_idle(CMD_ENABLE) ##0 !CMD_PARTITION |=> EMULATION_ON;
    endproperty
    property p_cmd_err;
        (CMD_PARTITION || CMD_ENABLE || CMD_DISABLE) && MEMORY_CONTROLLER_BUSY |=> ACCESS_ERROR;
    endproperty

    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_idle: assert property (p_ack_idle) else $error("idle access not acked");
    a_restore_stall: assert property (p_restore_stall) else $error("ack during restore");
    a_off_nopend: assert property (p_off_nopend) else $error("pending rose while off");
    a_pend_drain: assert property (p_pend_drain) else $error("pending count stuck");
    a_part: assert property (p_part) else $error("partition start wrong");
    a_enable: assert property (p_enable) else $error("enable ignored");
    a_cmd_err: assert property (p_cmd_err) else $error("busy command not flagged");
endmodule : emnv_manager_sva

bind emnv_manager emnv_manager_sva #(.NUM_SECT(NUM_SECT), .PROG_CYC(PROG_CYC)) u_sva
(
    .CLOCK, .SRST, .HOST_REQ, .HOST_ACK, .CMD_PARTITION, .CMD_SECTIONS, .CMD_ENABLE, .CMD_DISABLE,
    .MEMORY_CONTROLLER_BUSY, .PENDING_RECORD_COUNT, .EMULATION_ON, .ACCESS_ERROR
);

// ==== emnv_host.sv ====
// Host model making byte accesses on the memory port
`timescale 1ns/1ps
module emnv_host
(
    // Clock
    input wire logic clk,
    // Answer
    input wire logic ack,
    input wire logic [7:0] rdata,
    // Request
    output logic req,
    output logic we,
    output logic [9:0] addr,
    output logic [7:0] wdata
);
    initial
    begin
        req = 1'b0;
        we = 1'b0;
        addr = 10'h000;
        wdata = 8'h00;
    end

    // Lines flip on release so stale values never pass for held ones
    task acc(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q, output int n);
        n = 0;
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        addr <= a;
        wdata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 5000);
        q = rdata;
        req <= 1'b0;
        we <= ~w;
        addr <= ~a;
        wdata <= ~d;
    endtask : acc
endmodule : emnv_host

// ==== testbench.sv ====
// Self-checking bench of the record manager
`timescale 1ns/1ps
module testbench;
    logic clock, srst, blank, req, we, ack, busy, emu, aerr, cp, ce, cd;
    logic [9:0] addr;
    logic [7:0] wd, rd, q, d;
    logic [2:0] sects;
    logic [10:0] pend;
    logic [7:0] m [0:1023];
    logic [7:0] r [0:255];
    int errors, samples_checked, c;

    emnv_manager #(.NUM_SECT(4), .PROG_CYC(2)) uut
    (
        .CLOCK(clock), .CE(1'b1), .SRST(srst), .BLANK_FLASH(blank), .HOST_REQ(req), .HOST_WE(we),
        .HOST_ADDR(addr), .HOST_WDATA(wd), .HOST_RDATA(rd), .HOST_ACK(ack), .CMD_PARTITION(cp),
        .CMD_SECTIONS(sects), .CMD_ENABLE(ce), .CMD_DISABLE(cd), .MEMORY_CONTROLLER_BUSY(busy),
        .PENDING_RECORD_COUNT(pend), .EMULATION_ON(emu), .ACCESS_ERROR(aerr)
    );
    emnv_host h (.clk(clock), .ack(ack), .rdata(rd), .req(req), .we(we), .addr(addr), .wdata(wd));

    // Partition bytes come back from records, buffer bytes as written
    function logic [7:0] exp_rd(input logic [9:0] a);
        return (a < 10'h100) ? r[a[7:0]] : m[a];
    endfunction : exp_rd

    task chk(input logic [10:0] g, input logic [10:0] e);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task test_done;
        $display("Checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task cmd(input logic p, input logic e, input logic x, input logic [2:0] s);
        @(posedge clock);
        cp <= p;
        ce <= e;
        cd <= x;
        sects <= s;
        @(posedge clock);
        {cp, ce, cd} <= 3'h0;
        @(posedge clock);
    endtask : cmd

    task settle;
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while ((busy !== 1'b0 || pend !== 11'h000) && n < 20000);
        chk(n < 20000, 1);
    endtask : settle

    task wr(input logic [9:0] a, input logic [7:0] v);
        h.acc(1'b1, a, v, q, c);
        chk(c < 5000, 1);
        m[a] = v;
    endtask : wr

    task rd_chk(input logic [9:0] a);
        h.acc(1'b0, a, 8'h00, q, c);
        chk(c < 5000, 1);
        chk(q, exp_rd(a));
    endtask : rd_chk

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial
    begin
        #300000;
        errors++;
        test_done();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        errors = 0;
        samples_checked = 0;
        srst = 1'b1;
        blank = 1'b1;
        {cp, ce, cd} = 3'h0;
        sects = 3'h0;
        c = $urandom(32'h129a3616);
        @(posedge clock);
        blank <= 1'b0;
        @(posedge clock);
        srst <= 1'b0;
        cmd(1'b1, 1'b0, 1'b0, 3'h5);
        chk(aerr, 1);
        cmd(1'b1, 1'b0, 1'b0, 3'h1);
        chk({aerr, busy}, 2'b01);
        settle();
        for (int i = 0; i < 256; i++)
        begin
            r[i] = 8'hff;
            rd_chk(i[9:0]);
        end
        for (int k = 0; k < 18; k++)
        begin
            if (k == 6)
            begin
                cmd(1'b0, 1'b1, 1'b0, 3'h0);
                chk(emu, 1);
            end
            if (k == 12)
            begin
                settle();
                chk(pend, 0);
                cmd(1'b0, 1'b0, 1'b1, 3'h0);
                chk(emu, 0);
            end
            d = 8'($urandom);
            wr(k[9:0], d);
            wr(k[9:0] + 10'h100, ~d);
            if (k < 12)
                r[k] = d;
        end
        chk(pend, 0);
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        cmd(1'b0, 1'b1, 1'b0, 3'h0);
        chk(aerr, 1);
        h.acc(1'b0, 10'h000, 8'h00, q, c);
        chk(c > 200, 1);
        chk(q, r[0]);
        for (int k = 0; k < 18; k++)
        begin
            rd_chk(k[9:0]);
            rd_chk(k[9:0] + 10'h100);
        end
        test_done();
    end
endmodule : testbench
